// ---- core/cs_pkg.sv ----
// shared constants, widths and state codes for the chip-select and termination logic
package cs_pkg;

    // ****************************************************************
    // address map
    // ****************************************************************
    localparam logic [31:0] VEC_SP_ADDR      = 32'h0000_0000;
    localparam logic [31:0] VEC_PC_ADDR      = 32'h0000_0004;
    localparam logic [15:0] FLASH_RELOC_BASE = 16'hFFE0;

    // ****************************************************************
    // sizes and values after reset
    // ****************************************************************
    localparam int          NUM_CS          = 4;
    localparam int          WAIT_W          = 4;
    localparam int          SDRAM_WIDTH     = 16;
    localparam logic [3:0]  BOOT_WAITS_RST  = 4'hF;
    localparam logic [15:0] BOOT_MASK_RST   = 16'h001F;
    localparam logic [1:0]  SYNC_RST        = 2'h0;
    localparam logic [1:0]  ACK_N_SYNC_RST  = 2'h3;

    typedef enum logic [1:0] {
        ST_LAUNCH_VEC = 2'b00,
        ST_IDLE       = 2'b01,
        ST_CYCLE      = 2'b10
    } state_e;

endpackage

// ---- core/wait_state_counter.sv ----
// wait-state counter that raises the internal acknowledge after a programmed count
module wait_state_counter #(
    parameter int WAIT_W = cs_pkg::WAIT_W
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              start,
    input  wire logic              stop,
    input  wire logic [WAIT_W-1:0] waits,
    output logic                   hit
);

    logic              run_q;
    logic [WAIT_W-1:0] cnt_q;

    // start comes with the edge that pulls the chip select low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (start) begin
            run_q <= 1'b1;
        end else if (stop) begin
            run_q <= 1'b0;
        end
    end

    // saturates so a stuck cycle cannot wrap back onto the count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= '0;
        end else if (run_q && cnt_q != '1) begin
            cnt_q <= cnt_q + WAIT_W'(1);
        end
    end

    assign hit = run_q && (cnt_q == waits);

endmodule

// ---- core/chip_select_wait_state_ack.sv ----
// chip selects, boot decoding, vector fetch and bus-cycle termination
module chip_select_wait_state_ack #(
    parameter int NCS    = cs_pkg::NUM_CS,
    parameter int WAIT_W = cs_pkg::WAIT_W
) (
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    input  wire logic                  req,
    input  wire logic [31:0]           req_addr,
    input  wire logic                  req_write,
    input  wire logic [31:0]           req_wr_data,
    input  wire logic                  boot_mask_wr,
    input  wire logic [15:0]           boot_base_in,
    input  wire logic [15:0]           boot_mask_in,
    input  wire logic                  boot_auto_in,
    input  wire logic [WAIT_W-1:0]     boot_waits_in,
    input  wire logic                  boot_wp_in,
    input  wire logic [NCS-1:1][15:0]  cs_base,
    input  wire logic [NCS-1:1][15:0]  cs_mask,
    input  wire logic [NCS-1:1]        cs_enable,
    input  wire logic [NCS-1:1]        auto_ack_mode,
    input  wire logic [NCS-1:1][WAIT_W-1:0] cs_waits,
    input  wire logic [NCS-1:1]        cs_write_protect,
    input  wire logic                  sdram_enable,
    input  wire logic [15:0]           sdram_base,
    input  wire logic [15:0]           sdram_mask,
    input  wire logic [WAIT_W-1:0]     sdram_waits,
    input  wire logic                  ext_ack_n,
    input  wire logic [31:0]           bus_rd_data,
    output logic [NCS-1:0]             region_select_n,
    output logic                       sdram_cs_n,
    output logic                       bus_oe_n,
    output logic                       bus_rw_n,
    output logic [31:0]                bus_addr,
    output logic [31:0]                bus_wr_data,
    output logic                       port16,
    output logic                       xfer_done_ack,
    output logic                       xfer_err,
    output logic [31:0]                rd_data,
    output logic [31:0]                init_sp,
    output logic [31:0]                init_pc,
    output logic                       vectors_ready
);

    // ****************************************************************
    // reset release and pin synchronisers
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [1:0] ack_sync_q;
    logic       ext_ack_s;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= cs_pkg::SYNC_RST;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_sync_q <= cs_pkg::ACK_N_SYNC_RST;
        end else begin
            ack_sync_q <= {ack_sync_q[0], ext_ack_n};
        end
    end
    assign ext_ack_s = !ack_sync_q[1];

    function automatic logic range_hit(input logic [31:0] a, input logic [15:0] base,
                                       input logic [15:0] mask);
        range_hit = ((a[31:16] ^ base) & ~mask) == 16'h0000;
    endfunction

    // ****************************************************************
    // boot select configuration
    // ****************************************************************
    logic              boot_global_select_q;
    logic [15:0]       boot_base_q;
    logic [15:0]       boot_select_mask_reg_q;
    logic              boot_auto_q;
    logic [WAIT_W-1:0] boot_waits_q;
    logic              boot_wp_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            boot_global_select_q   <= 1'b1;
            boot_base_q            <= cs_pkg::FLASH_RELOC_BASE;
            boot_select_mask_reg_q <= cs_pkg::BOOT_MASK_RST;
            boot_auto_q            <= 1'b1;
            boot_waits_q           <= cs_pkg::BOOT_WAITS_RST;
            boot_wp_q              <= 1'b0;
        end else if (boot_mask_wr) begin
            boot_global_select_q   <= 1'b0;
            boot_base_q            <= boot_base_in;
            boot_select_mask_reg_q <= boot_mask_in;
            boot_auto_q            <= boot_auto_in;
            boot_waits_q           <= boot_waits_in;
            boot_wp_q              <= boot_wp_in;
        end
    end

    // ****************************************************************
    // launch and decode
    // ****************************************************************
    cs_pkg::state_e    state_q;
    logic              vec_idx_q;
    logic              launch;
    logic [31:0]       l_addr;
    logic              l_write;
    logic [NCS:0]      sel_d;
    logic              sel_auto;
    logic [WAIT_W-1:0] sel_waits;
    logic              sel_wp;
    localparam int     SDRAM_W = cs_pkg::SDRAM_WIDTH;

    assign launch  = (state_q == cs_pkg::ST_LAUNCH_VEC) || (state_q == cs_pkg::ST_IDLE && req);
    assign l_addr  = (state_q == cs_pkg::ST_LAUNCH_VEC) ?
                     (vec_idx_q ? cs_pkg::VEC_PC_ADDR : cs_pkg::VEC_SP_ADDR) : req_addr;
    assign l_write = (state_q == cs_pkg::ST_LAUNCH_VEC) ? 1'b0 : req_write;

    // lowest select wins an overlap; sdram is bit NCS
    always_comb begin
        sel_d     = '0;
        sel_auto  = 1'b0;
        sel_waits = '0;
        sel_wp    = 1'b0;
        if (boot_global_select_q ||
            range_hit(l_addr, boot_base_q, boot_select_mask_reg_q)) begin
            sel_d[0]  = 1'b1;
            sel_auto  = boot_auto_q;
            sel_waits = boot_waits_q;
            sel_wp    = boot_wp_q;
        end else begin
            for (int i = NCS - 1; i >= 1; i--) begin
                if (cs_enable[i] && range_hit(l_addr, cs_base[i], cs_mask[i])) begin
                    sel_d     = '0;
                    sel_d[i]  = 1'b1;
                    sel_auto  = auto_ack_mode[i];
                    sel_waits = cs_waits[i];
                    sel_wp    = cs_write_protect[i];
                end
            end
            if (sel_d == '0 && sdram_enable && range_hit(l_addr, sdram_base, sdram_mask)) begin
                sel_d[NCS] = 1'b1;
                sel_auto   = 1'b1;
                sel_waits  = sdram_waits;
            end
        end
    end

    logic refuse;
    assign refuse = (sel_d == '0) || (sel_wp && l_write);

    // ****************************************************************
    // cycle state
    // ****************************************************************
    logic              cur_auto_q;
    logic [WAIT_W-1:0] cur_waits_q;
    logic              wc_hit;
    logic              ack_now;
    logic              done;

    assign ack_now = cur_auto_q ? wc_hit : ext_ack_s;
    assign done    = (state_q == cs_pkg::ST_CYCLE) && ack_now;
    assign xfer_done_ack = done && vectors_ready;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= cs_pkg::ST_LAUNCH_VEC;
        end else begin
            unique case (state_q)
                cs_pkg::ST_LAUNCH_VEC: begin
                    state_q <= refuse ? cs_pkg::ST_IDLE : cs_pkg::ST_CYCLE;
                end
                cs_pkg::ST_IDLE: begin
                    if (launch && !refuse) begin
                        state_q <= cs_pkg::ST_CYCLE;
                    end
                end
                cs_pkg::ST_CYCLE: begin
                    if (ack_now) begin
                        state_q <= (!vectors_ready && !vec_idx_q) ?
                                   cs_pkg::ST_LAUNCH_VEC : cs_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= cs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vec_idx_q     <= 1'b0;
            vectors_ready <= 1'b0;
            init_sp       <= '0;
            init_pc       <= '0;
        end else if (state_q == cs_pkg::ST_LAUNCH_VEC && refuse) begin
            vectors_ready <= 1'b1;
        end else if (done && !vectors_ready) begin
            vec_idx_q <= 1'b1;
            if (vec_idx_q) begin
                init_pc       <= bus_rd_data;
                vectors_ready <= 1'b1;
            end else begin
                init_sp <= bus_rd_data;
            end
        end
    end

    // data is sampled on the acknowledge: the wait count for auto cycles, else the synchronised pin two cycles after it moved
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (xfer_done_ack && bus_rw_n) begin
            rd_data <= bus_rd_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            region_select_n <= '1;
            sdram_cs_n      <= 1'b1;
            bus_oe_n        <= 1'b1;
            bus_rw_n        <= 1'b1;
            bus_addr        <= '0;
            bus_wr_data     <= '0;
            port16          <= 1'b0;
            cur_auto_q      <= 1'b0;
            cur_waits_q     <= '0;
        end else if (launch && !refuse && state_q != cs_pkg::ST_CYCLE) begin
            region_select_n <= ~sel_d[NCS-1:0];
            sdram_cs_n      <= ~sel_d[NCS];
            bus_oe_n        <= l_write;
            bus_rw_n        <= ~l_write;
            bus_addr        <= l_addr;
            bus_wr_data     <= req_wr_data;
            port16          <= sel_d[NCS] && (SDRAM_W == 16);
            cur_auto_q      <= sel_auto;
            cur_waits_q     <= sel_waits;
        end else if (done) begin
            region_select_n <= '1;
            sdram_cs_n      <= 1'b1;
            bus_oe_n        <= 1'b1;
            bus_rw_n        <= 1'b1;
            port16          <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_err <= 1'b0;
        end else begin
            xfer_err <= launch && refuse && state_q == cs_pkg::ST_IDLE;
        end
    end

    wait_state_counter #(.WAIT_W(WAIT_W)) u_wait (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (launch && !refuse && state_q != cs_pkg::ST_CYCLE),
        .stop  (done),
        .waits (cur_waits_q),
        .hit   (wc_hit)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [WAIT_W:0] cyc_cnt_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt_q <= '0;
        end else if (state_q != cs_pkg::ST_CYCLE) begin
            cyc_cnt_q <= '0;
        end else begin
            cyc_cnt_q <= cyc_cnt_q + (WAIT_W+1)'(1);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_vec_launch(idx);
        state_q == cs_pkg::ST_LAUNCH_VEC && vec_idx_q == idx && !refuse;
    endsequence
    sequence s_open;
        state_q == cs_pkg::ST_CYCLE && !ack_now;
    endsequence

    AST_VEC_SP: assert property (s_vec_launch(1'b0) |=> bus_addr == cs_pkg::VEC_SP_ADDR && !region_select_n[0]) else $error("stack pointer fetch misplaced");
    AST_VEC_PC: assert property (s_vec_launch(1'b1) |=> bus_addr == cs_pkg::VEC_PC_ADDR && bus_rw_n) else $error("program counter fetch misplaced");
    AST_BOOT_GLOBAL: assert property (boot_global_select_q && launch && state_q != cs_pkg::ST_CYCLE |=> !region_select_n[0]) else $error("boot select missed an access");
    AST_MASK_WRITE: assert property (boot_mask_wr |=> !boot_global_select_q) else $error("boot select still global");
    AST_CS_CTRL: assert property (state_q == cs_pkg::ST_CYCLE |-> ((~region_select_n != '0) || !sdram_cs_n) && (bus_oe_n != bus_rw_n)) else $error("cycle without select or controls");
    AST_HOLD: assert property (s_open |=> state_q == cs_pkg::ST_CYCLE && $stable(region_select_n) && $stable(sdram_cs_n)) else $error("cycle closed without acknowledge");
    AST_AUTO_COUNT: assert property (done && cur_auto_q |-> cyc_cnt_q == {1'b0, cur_waits_q}) else $error("internal acknowledge at wrong count");
    AST_EXT_WAIT: assert property (state_q == cs_pkg::ST_CYCLE && !cur_auto_q && !ext_ack_s |-> !xfer_done_ack) else $error("acknowledge without external answer");
    AST_ACK_ONE: assert property (xfer_done_ack |=> !xfer_done_ack) else $error("acknowledge longer than one clock");
    AST_BOOT_AUTO: assert property (boot_global_select_q && state_q == cs_pkg::ST_CYCLE && !region_select_n[0] |-> cur_auto_q) else $error("boot select not auto-acknowledged");
    AST_RELOC: assert property (boot_global_select_q |-> boot_base_q == cs_pkg::FLASH_RELOC_BASE) else $error("boot base moved before configuration");
    AST_SDRAM16: assert property (!sdram_cs_n |-> port16) else $error("sdram cycle not 16 bits wide");
    AST_ONE_SELECT: assert property ($onehot0({~region_select_n, ~sdram_cs_n})) else $error("more than one select low");
    AST_WAIT_PROG: assert property (state_q == cs_pkg::ST_CYCLE && cur_auto_q && cyc_cnt_q < {1'b0, cur_waits_q} |-> !done) else $error("cycle shorter than programmed waits");

endmodule

// ---- tb/mem_model.sv ----
// external bus devices: boot flash, a self-acknowledging device on select 1, and SDRAM
module mem_model (
    input  wire logic        mclk,
    input  wire logic [3:0]  region_select_n,
    input  wire logic        sdram_cs_n,
    input  wire logic        bus_oe_n,
    input  wire logic [31:0] bus_addr,
    input  wire logic [3:0]  ack_delay,
    output logic             ext_ack_n,
    output logic [31:0]      bus_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0]  wait_q;
    logic [31:0] junk_q = 32'h0F0F_0F0F;
    logic        drive;

    assign drive = !bus_oe_n && (!(&region_select_n) || !sdram_cs_n);
    assign bus_rd_data = drive ? ({~bus_addr[15:0], bus_addr[31:16]} ^ 32'h5A3C_C3A5) : junk_q;

    // released lines carry a pattern that changes every cycle, so a late sample cannot match
    always_ff @(posedge mclk) begin
        junk_q <= ~bus_rd_data;
    end

    // flash and SDRAM cannot acknowledge; only the select 1 device drives the pin
    always_ff @(posedge mclk) begin
        if (region_select_n[1]) begin
            wait_q    <= 4'h0;
            ext_ack_n <= 1'b1;
        end else if (wait_q == ack_delay) begin
            ext_ack_n <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ---- tb/chip_select_wait_state_ack_tb.sv ----
// self-checking bench for the chip-select and bus-cycle termination block
module chip_select_wait_state_ack_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // signals
    // ****************************************************************
    logic                  mclk = 1'b0;
    logic                  nrst, req, req_write, boot_mask_wr, boot_auto_in, boot_wp_in;
    logic                  sdram_enable, ext_ack_n, port16, xfer_done_ack, xfer_err;
    logic                  sdram_cs_n, bus_oe_n, bus_rw_n, vectors_ready;
    logic [31:0]           req_addr, req_wr_data, bus_rd_data, bus_addr, bus_wr_data;
    logic [31:0]           rd_data, init_sp, init_pc;
    logic [15:0]           boot_base_in, boot_mask_in, sdram_base, sdram_mask;
    logic [3:0]            boot_waits_in, sdram_waits, ack_delay, region_select_n;
    logic [3:1][15:0]      cs_base, cs_mask;
    logic [3:1][3:0]       cs_waits;
    logic [3:1]            cs_enable, auto_ack_mode, cs_write_protect;
    int                    err_total = 0;
    int                    total_checks = 0;
    int                    i, k, boot_n;

    always #50 mclk = ~mclk;

    chip_select_wait_state_ack chip_select_wait_state_ack_i (
        .mclk, .nrst, .req, .req_addr, .req_write, .req_wr_data, .boot_mask_wr, .boot_base_in,
        .boot_mask_in, .boot_auto_in, .boot_waits_in, .boot_wp_in, .cs_base, .cs_mask,
        .cs_enable, .auto_ack_mode, .cs_waits, .cs_write_protect, .sdram_enable, .sdram_base,
        .sdram_mask, .sdram_waits, .ext_ack_n, .bus_rd_data, .region_select_n, .sdram_cs_n,
        .bus_oe_n, .bus_rw_n, .bus_addr, .bus_wr_data, .port16, .xfer_done_ack, .xfer_err,
        .rd_data, .init_sp, .init_pc, .vectors_ready
    );

    mem_model mem_model_i (
        .mclk, .region_select_n, .sdram_cs_n, .bus_oe_n, .bus_addr, .ack_delay, .ext_ack_n,
        .bus_rd_data
    );

    // ****************************************************************
    // reference model and helpers
    // ****************************************************************
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {~a[15:0], a[31:16]} ^ 32'h5A3C_C3A5;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // sel 0..3 region select, 4 SDRAM, 5 refused; lo..hi bounds the cycles with a select low
    task automatic access(input logic [31:0] a, input logic w, input int sel, input int lo,
                          input int hi);
        int          n;
        logic [31:0] wd;
        logic [3:0]  exp_n;
        wd = $urandom;
        exp_n = (sel < 4) ? ~(4'h1 << sel) : 4'hF;
        @(posedge mclk);
        req <= 1'b1;
        req_addr <= a;
        req_write <= w;
        req_wr_data <= wd;
        @(posedge mclk);
        req <= 1'b0;
        @(negedge mclk);
        if (sel == 5) begin
            chk({31'h0, xfer_err}, 32'h1, "refusal flag");
            chk({27'h0, region_select_n, sdram_cs_n}, 32'h1F, "selects on refusal");
        end else begin
            chk({31'h0, xfer_err}, 32'h0, "refusal flag on accepted access");
            for (n = 1; n < 40; n++) begin
                chk({region_select_n, sdram_cs_n, port16, bus_rw_n, bus_oe_n},
                    {exp_n, sel != 4, sel == 4, !w, w}, "bus controls");
                chk(bus_addr, a, "bus address");
                if (w) chk(bus_wr_data, wd, "write data");
                if (xfer_done_ack === 1'b1) break;
                @(negedge mclk);
            end
            chk(n >= lo && n <= hi, 32'h1, "cycle length");
            @(negedge mclk);
            chk({27'h0, region_select_n, sdram_cs_n}, 32'h1F, "selects after ack");
            if (!w) chk(rd_data, mem_word(a), "read data");
        end
    endtask

    // ****************************************************************
    // watchdog and main sequence
    // ****************************************************************
    initial begin
        repeat (4000) @(posedge mclk);
        err_total++;
        complete_run();
    end

    initial begin
        nrst = 1'b0;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 32'h0;
        req_wr_data = 32'h0;
        boot_mask_wr = 1'b0;
        boot_base_in = cs_pkg::FLASH_RELOC_BASE;
        boot_mask_in = 16'h001F;
        boot_auto_in = 1'b1;
        boot_waits_in = 4'h6;
        boot_wp_in = 1'b1;
        cs_base = {16'h6000, 16'h5000, 16'h4000};
        cs_mask = '0;
        cs_enable = 3'h7;
        auto_ack_mode = 3'h6;
        cs_waits = {4'h1, 4'h0, 4'h0};
        cs_write_protect = 3'h0;
        sdram_enable = 1'b1;
        sdram_base = 16'h0000;
        sdram_mask = 16'h003F;
        sdram_waits = 4'h3;
        ack_delay = 4'h0;
        boot_n = int'(cs_pkg::BOOT_WAITS_RST) + 1;
        void'($urandom(32'hABF322AC));
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        for (i = 0; i < 20 && region_select_n[0] !== 1'b0; i++) @(negedge mclk);
        chk(bus_addr, cs_pkg::VEC_SP_ADDR, "first vector address");
        for (i = 0; i < 100 && vectors_ready !== 1'b1; i++) @(negedge mclk);
        chk(init_sp, mem_word(cs_pkg::VEC_SP_ADDR), "initial stack pointer");
        chk(init_pc, mem_word(cs_pkg::VEC_PC_ADDR), "initial program counter");
        // before the mask write any address lands on the boot select
        repeat (2) access($urandom, 1'b0, 0, boot_n, boot_n);
        @(posedge mclk);
        boot_mask_wr <= 1'b1;
        @(posedge mclk);
        boot_mask_wr <= 1'b0;
        access(32'hFFE0_0100, 1'b0, 0, 7, 7);
        access(32'hFFFF_FFFC, 1'b0, 0, 7, 7);
        access(32'hFFE0_0000, 1'b1, 5, 0, 0);
        access(cs_pkg::VEC_SP_ADDR, 1'b0, 4, 4, 4);
        access(32'h7000_0000, 1'b0, 5, 0, 0);
        for (i = 0; i < 2; i++) begin
            k = i * 9;
            @(posedge mclk);
            ack_delay <= k[3:0];
            access(32'h4000_0010, 1'b0, 1, k + 3, k + 6);
        end
        for (i = 0; i < 5; i++) begin
            k = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(14, 1);
            @(posedge mclk);
            cs_waits[2] <= k[3:0];
            access(32'h5000_0000 + ($urandom & 32'hFFFC), i[0], 2, k + 1, k + 1);
        end
        access(32'h6000_0040, 1'b1, 3, 2, 2);
        access(32'h6000_0040, 1'b0, 3, 2, 2);
        @(posedge mclk);
        cs_write_protect <= 3'h4;
        cs_enable <= 3'h5;
        access(32'h6000_0040, 1'b1, 5, 0, 0);
        access(32'h5000_0000, 1'b0, 5, 0, 0);
        access(32'h6000_0040, 1'b0, 3, 2, 2);
        // a reset in mid-run must bring back the vector fetch and the global boot select
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        for (i = 0; i < 100 && vectors_ready !== 1'b1; i++) @(negedge mclk);
        chk(init_pc, mem_word(cs_pkg::VEC_PC_ADDR), "program counter after reset");
        access(32'h6000_0040, 1'b0, 0, boot_n, boot_n);
        complete_run();
    end
endmodule
